/* File: src/isl_exec.sv */
// Execution unit for increment-skip, inclusive OR and pointer-load instructions
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/100ps
module isl_exec #(
  parameter int MEM_WORDS = 4096    // Data space size
) (
  input  wire logic        pclk,    // Core clock
  input  wire logic        presetn, // Async reset, active low
  input  wire logic        psel,    // APB select
  input  wire logic        penable, // APB enable
  input  wire logic        pwrite,  // APB direction
  input  wire logic [7:0]  paddr,   // APB byte address
  input  wire logic [31:0] pwdata,  // APB write data
  output logic      [31:0] prdata,  // APB read data
  output logic             pready,  // APB ready
  output logic             pslverr, // APB error
  output logic             busy     // Instruction in progress
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [7:0]  acc_reg;
  logic [3:0]  bank_sel_reg;
  logic [7:0]  status_reg;
  logic        ext_en_reg;
  logic [15:0] instr_reg;
  logic [15:0] next_word_reg;
  logic        go_reg;
  logic [11:0] fptr_reg [3];
  logic [7:0]  mem [MEM_WORDS];
  isl_pkg::isl_phase_t phase_reg;
  logic [1:0]  skip_cnt_reg;
  logic        second_reg;
  logic [7:0]  opnd_reg;
  logic [7:0]  result_reg;
  logic        skip_reg;
  logic [11:0] eaddr_reg;

  // Effective data address from bank bit, bank register and index mode
  function automatic logic [11:0] isl_eaddr(input isl_pkg::isl_fields_t f,
                                            input logic [3:0] bank_select_reg, input logic ext,
                                            input logic [11:0] fp2);
    logic [11:0] a;
    a = '0;
    if (f.bank) begin
      a = {bank_select_reg, f.faddr};
    end else if (ext && f.faddr <= isl_pkg::ISL_IDX_LIMIT) begin
      a = fp2 + {4'h0, f.faddr};
    end else if (f.faddr >= isl_pkg::ISL_ACC_SPLIT) begin
      a = {isl_pkg::ISL_ACC_HIGH, f.faddr};
    end else begin
      a = {4'h0, f.faddr};
    end
    return a;
  endfunction

  // Data memory index seen through the APB window: low half of the selected bank
  function automatic logic [11:0] isl_win_addr(input logic [3:0] bank_select_reg, input logic [7:0] a);
    return {bank_select_reg, 1'b0, a[6:0]};
  endfunction

  isl_pkg::isl_fields_t fld;
  assign fld = '{dest: instr_reg[9], bank: instr_reg[8], faddr: instr_reg[7:0],
                 lit: instr_reg[7:0]};

  // Opcode decode of the current instruction word
  logic is_insnz;
  logic is_insz;
  logic is_orwf;
  logic is_orlw;
  logic is_lptr;
  logic is_incskip;
  logic next_two;
  assign is_insnz   = instr_reg[15:10] == isl_pkg::ISL_OP_INSNZ;
  assign is_insz    = instr_reg[15:10] == isl_pkg::ISL_OP_INSZ;
  assign is_orwf    = instr_reg[15:10] == isl_pkg::ISL_OP_ORWF;
  assign is_orlw    = instr_reg[15:8]  == isl_pkg::ISL_OP_ORLW;
  assign is_lptr    = instr_reg[15:6]  == isl_pkg::ISL_OP_LPTR;
  assign is_incskip = is_insnz || is_insz;
  // Two-word instructions start with 1100 or 1110 11x in their first word;
  // only these stretch a taken skip to three cycles, other words cost two
  assign next_two   = next_word_reg[15:12] == isl_pkg::ISL_TWO_MOVE ||
                      next_word_reg[15:10] == isl_pkg::ISL_TWO_JUMP;

  // APB strobes: writes land in the access cycle, reads are fetched in setup
  logic wr_hit;
  logic rd_setup;
  logic mem_hit;
  assign wr_hit   = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign mem_hit  = (paddr & isl_pkg::ISL_MEM_MASK) == isl_pkg::ISL_MEM_MASK;

  // ------------------------------------------------------------
  // Phase sequencer
  // ------------------------------------------------------------
  // Four phases per cycle; skipped cycles still walk Q1..Q4 idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg    <= isl_pkg::ISL_Q1;
      busy         <= 1'b0;
      skip_cnt_reg <= 2'h0;
      second_reg   <= 1'b0;
    end else if (!busy) begin
      busy <= go_reg;
    end else begin
      case (phase_reg)
        isl_pkg::ISL_Q1: phase_reg <= isl_pkg::ISL_Q2;
        isl_pkg::ISL_Q2: phase_reg <= isl_pkg::ISL_Q3;
        isl_pkg::ISL_Q3: phase_reg <= isl_pkg::ISL_Q4;
        isl_pkg::ISL_Q4: begin
          phase_reg <= isl_pkg::ISL_Q1;
          if (skip_cnt_reg != 2'h0) begin
            skip_cnt_reg <= skip_cnt_reg - 2'h1;
            busy         <= skip_cnt_reg != 2'h1;
          end else if (is_lptr && !second_reg) begin
            second_reg <= 1'b1;
          end else if (skip_reg && (is_insnz || is_insz)) begin
            skip_cnt_reg <= next_two ? 2'h2 : 2'h1;
          end else begin
            second_reg <= 1'b0;
            busy       <= 1'b0;
          end
        end
        default: phase_reg <= isl_pkg::ISL_Q1;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Datapath phases
  // ------------------------------------------------------------
  logic active;
  assign active = busy && skip_cnt_reg == 2'h0;

  // Q1 decode address, Q2 read operand, Q3 process
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eaddr_reg  <= 12'h000;
      opnd_reg   <= 8'h00;
      result_reg <= 8'h00;
      skip_reg   <= 1'b0;
    end else if (active) begin
      case (phase_reg)
        isl_pkg::ISL_Q1: eaddr_reg <= isl_eaddr(fld, bank_sel_reg, ext_en_reg,
                                                fptr_reg[2]);
        isl_pkg::ISL_Q2: opnd_reg <= is_orlw ? fld.lit : mem[eaddr_reg];
        isl_pkg::ISL_Q3: begin
          if (is_insnz || is_insz) begin
            result_reg <= opnd_reg + 8'h01;
            skip_reg   <= is_insnz ? (opnd_reg != 8'hff)
                                   : (opnd_reg == 8'hff);
          end else begin
            result_reg <= acc_reg | opnd_reg;
            skip_reg   <= 1'b0;
          end
        end
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Software-loaded configuration
  // ------------------------------------------------------------
  // Loaded only while idle, so a running instruction never sees its word change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_sel_reg  <= 4'h0;
      ext_en_reg    <= 1'b0;
      instr_reg     <= 16'h0000;
      next_word_reg <= 16'h0000;
      go_reg        <= 1'b0;
    end else begin
      go_reg <= 1'b0;
      if (wr_hit && !mem_hit && !busy) begin
        case (paddr)
          isl_pkg::ISL_OFF_CTRL: begin
            ext_en_reg <= pwdata[1];
            go_reg     <= pwdata[0];
          end
          isl_pkg::ISL_OFF_INSTR: begin
            instr_reg     <= pwdata[15:0];
            next_word_reg <= pwdata[31:16];
          end
          isl_pkg::ISL_OFF_BANK: bank_sel_reg <= pwdata[3:0];
          default: ;
        endcase
      end
    end
  end

  // Destination write strobe of a live (not skipped) cycle
  logic q4_write;
  assign q4_write = active && phase_reg == isl_pkg::ISL_Q4;

  // Accumulator: software load while idle, destination write in Q4
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg <= 8'h00;
    end else if (q4_write) begin
      if (is_orlw || ((is_orwf || is_incskip) && !fld.dest)) begin
        acc_reg <= result_reg;
      end
    end else if (wr_hit && !busy && paddr == isl_pkg::ISL_OFF_ACC) begin
      acc_reg <= pwdata[7:0];
    end
  end

  // Status: only the OR forms touch N and Z; the other flags keep their value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= 8'h00;
    end else if (q4_write) begin
      if (is_orlw || is_orwf) begin
        status_reg[isl_pkg::ISL_ST_N] <= result_reg[7];
        status_reg[isl_pkg::ISL_ST_Z] <= result_reg == 8'h00;
      end
    end else if (wr_hit && !busy && paddr == isl_pkg::ISL_OFF_STATUS) begin
      status_reg <= pwdata[7:0];
    end
  end

  // Pointer load: high part from the first word, low byte from the second.
  // Index 3 names no pointer: the load is dropped but still takes two cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 3; i++) begin
        fptr_reg[i] <= 12'h000;
      end
    end else if (q4_write && is_lptr && instr_reg[5:4] != isl_pkg::ISL_PTR_NONE) begin
      if (!second_reg) begin
        fptr_reg[instr_reg[5:4]][11:8] <= instr_reg[3:0];
      end else begin
        fptr_reg[instr_reg[5:4]][7:0] <= next_word_reg[7:0];
      end
    end
  end

  // File memory write: destination write in Q4 or software port while idle
  always_ff @(posedge pclk) begin
    if (q4_write && fld.dest && (is_orwf || is_incskip)) begin
      mem[eaddr_reg] <= result_reg;
    end else if (wr_hit && mem_hit && !busy) begin
      mem[isl_win_addr(bank_sel_reg, paddr)] <= pwdata[7:0];
    end
  end

  // ------------------------------------------------------------
  // APB read side
  // ------------------------------------------------------------
  // Single wait-free answer; one registered cycle of data latency hidden by setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (rd_setup) begin
        if (mem_hit) begin
          prdata <= {24'h0, mem[isl_win_addr(bank_sel_reg, paddr)]};
        end else begin
          case (paddr)
            isl_pkg::ISL_OFF_CTRL:   prdata <= {30'h0, ext_en_reg, busy};
            isl_pkg::ISL_OFF_INSTR:  prdata <= {next_word_reg, instr_reg};
            isl_pkg::ISL_OFF_ACC:    prdata <= {24'h0, acc_reg};
            isl_pkg::ISL_OFF_BANK:   prdata <= {28'h0, bank_sel_reg};
            isl_pkg::ISL_OFF_STATUS: prdata <= {24'h0, status_reg};
            isl_pkg::ISL_OFF_FPTR0:  prdata <= {20'h0, fptr_reg[0]};
            isl_pkg::ISL_OFF_FPTR1:  prdata <= {20'h0, fptr_reg[1]};
            isl_pkg::ISL_OFF_FPTR2:  prdata <= {20'h0, fptr_reg[2]};
            isl_pkg::ISL_OFF_STATE:  prdata <= {27'h0, skip_reg, skip_cnt_reg,
                                                second_reg, busy};
            default:                 pslverr <= 1'b1;
          endcase
        end
      end
    end
  end

endmodule

/* File: src/isl_pkg.sv */
// Package for the increment-skip / OR / pointer-load execution block
package isl_pkg;
  // APB register byte offsets
  localparam logic [7:0] ISL_OFF_CTRL   = 8'h00;
  localparam logic [7:0] ISL_OFF_INSTR  = 8'h04;
  localparam logic [7:0] ISL_OFF_ACC    = 8'h08;
  localparam logic [7:0] ISL_OFF_BANK   = 8'h0c;
  localparam logic [7:0] ISL_OFF_STATUS = 8'h10;
  localparam logic [7:0] ISL_OFF_FPTR0  = 8'h14;
  localparam logic [7:0] ISL_OFF_FPTR1  = 8'h18;
  localparam logic [7:0] ISL_OFF_FPTR2  = 8'h1c;
  localparam logic [7:0] ISL_OFF_STATE  = 8'h20;
  localparam logic [7:0] ISL_OFF_MEM    = 8'h80;
  localparam logic [7:0] ISL_MEM_MASK   = 8'h80;

  // Opcode patterns
  localparam logic [5:0] ISL_OP_INSNZ  = 6'h12;  // 0100 10
  localparam logic [5:0] ISL_OP_INSZ   = 6'h0f;  // 0011 11
  localparam logic [5:0] ISL_OP_ORWF   = 6'h04;  // 0001 00
  localparam logic [7:0] ISL_OP_ORLW   = 8'h09;  // 0000 1001
  localparam logic [9:0] ISL_OP_LPTR   = 10'h3b8; // 1110 1110 00
  localparam logic [3:0] ISL_OP_LPTR2  = 4'hf;   // second word 1111 0000
  localparam logic [3:0] ISL_OP_LPTR2L = 4'h0;
  localparam logic [7:0] ISL_IDX_LIMIT = 8'h5f;  // indexed offset when f <= 95
  localparam logic [7:0] ISL_ACC_SPLIT = 8'h80;  // access bank upper half start
  localparam logic [3:0] ISL_ACC_HIGH  = 4'hf;   // page holding the access bank upper half
  localparam logic [1:0] ISL_PTR_NONE  = 2'h3;   // pointer index that names no register

  // First-word prefixes of two-word instructions in the following program word
  localparam logic [3:0] ISL_TWO_MOVE  = 4'hc;   // 1100
  localparam logic [5:0] ISL_TWO_JUMP  = 6'h3b;  // 1110 11

  // Status bits
  localparam int ISL_ST_N = 4;
  localparam int ISL_ST_Z = 2;

  typedef enum logic [2:0] {
    ISL_Q1, ISL_Q2, ISL_Q3, ISL_Q4
  } isl_phase_t;

  // Decoded instruction word
  typedef struct packed {
    logic       dest;
    logic       bank;
    logic [7:0] faddr;
    logic [7:0] lit;
  } isl_fields_t;
endpackage

/* File: test/isl_exec_asserts.sv */
// Concurrent checks on the APB face and busy timing of the execution block
`timescale 1ns/100ps
module isl_exec_chk #(
  parameter int MEM_WORDS = 4096   // Data space size
) (
  input wire logic        pclk,    // Core clock
  input wire logic        presetn, // Async reset, active low
  input wire logic        psel,    // APB select
  input wire logic        penable, // APB enable
  input wire logic        pwrite,  // APB direction
  input wire logic [7:0]  paddr,   // APB byte address
  input wire logic [31:0] pwdata,  // APB write data
  input wire logic [31:0] prdata,  // APB read data
  input wire logic        pready,  // APB ready
  input wire logic        pslverr, // APB error
  input wire logic        busy     // Instruction in progress
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ---------------------------------------------------------------
  // Busy run length
  // ---------------------------------------------------------------
  // Five bits suffice: the longest legal run is twelve cycles
  logic [4:0] busy_len_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_len_reg <= 5'h00;
    end else begin
      busy_len_reg <= busy ? busy_len_reg + 5'h01 : 5'h00;
    end
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  chk_ready_zero_wait: assert property (psel && !penable |=> pready)
    else $error("pready missing in access cycle");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held beyond one cycle");
  chk_ready_needs_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access cycle");
  chk_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_go_starts_busy: assert property (psel && penable && pready && pwrite &&
    paddr == 8'h00 && pwdata[0] && !busy |-> ##[2:3] busy)
    else $error("go write did not start execution");
  chk_busy_four_phases: assert property ($rose(busy) |-> busy [*4])
    else $error("instruction shorter than four phases");
  chk_busy_len_max: assert property (busy_len_reg <= 5'h0c)
    else $error("instruction longer than three cycles");
  chk_busy_len_whole: assert property ($fell(busy) |->
    busy_len_reg inside {5'h04, 5'h08, 5'h0c})
    else $error("instruction not a whole number of cycles");
endmodule

bind isl_exec isl_exec_chk #(.MEM_WORDS(MEM_WORDS)) u_isl_exec_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .busy(busy)
);

/* File: test/tb_top.sv */
// Self-checking bench for the increment-skip, OR and pointer-load block
`timescale 1ns/100ps
module tb_top;
  localparam logic [7:0] ACC = isl_pkg::ISL_OFF_ACC;
  localparam logic [7:0] STS = isl_pkg::ISL_OFF_STATUS;
  localparam logic [7:0] MEM_F = 8'ha0;  // Bank 2, file 0x20
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        busy;
  logic [31:0] rd;
  logic        err;
  int          fail_count = 0;
  int          num_checks = 0;
  int          cycles = 0;
  // Increment table: word, file before, cycles, file after, acc after
  logic [31:0] inc_ins [6] = '{32'h0000_3f20, 32'hc000_3f20, 32'hc000_3f20,
                               32'h0000_4b20, 32'hc000_4b20, 32'h0000_4920};
  logic [7:0]  inc_in  [6] = '{8'hff, 8'hff, 8'h10, 8'h10, 8'hff, 8'h10};
  int          inc_cyc [6] = '{8, 12, 4, 8, 4, 8};
  logic [7:0]  inc_out [6] = '{8'h00, 8'h00, 8'h11, 8'h11, 8'h00, 8'h10};
  logic [7:0]  inc_acc [6] = '{8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h11};

  always #5 pclk = ~pclk;

  isl_exec u_isl_exec (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .busy(busy));

  // Hang guard: far above the few hundred cycles the tests need
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  // One APB transfer; the idle edge after it keeps strobes from toggling twice
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(nm, e, rd);
  endtask

  // Load a word pair, start it, and measure the busy run
  task automatic run(input logic [31:0] ins, input logic ext, input int n_exp);
    int n;
    apb(isl_pkg::ISL_OFF_INSTR, 1'b1, ins);
    apb(isl_pkg::ISL_OFF_CTRL, 1'b1, {30'h0, ext, 1'b1});
    n = 0;
    while (busy !== 1'b1 && n < 8) begin
      @(posedge pclk);
      n++;
    end
    n = 0;
    while (busy === 1'b1) begin
      @(posedge pclk);
      n++;
    end
    chk("busy_cycles", n_exp, n);
  endtask

  task automatic test_incr();
    apb(isl_pkg::ISL_OFF_BANK, 1'b1, 32'h2);
    apb(STS, 1'b1, 32'h1f);
    for (int i = 0; i < 6; i++) begin
      apb(MEM_F, 1'b1, {24'h0, inc_in[i]});
      apb(ACC, 1'b1, 32'h55);
      run(inc_ins[i], 1'b0, inc_cyc[i]);
      rchk("inc_file", MEM_F, {24'h0, inc_out[i]});
      rchk("inc_acc", ACC, {24'h0, inc_acc[i]});
      rchk("inc_status", STS, 32'h1f);
    end
  endtask

  task automatic test_or();
    apb(ACC, 1'b1, 32'h9a);
    run(32'h0935, 1'b0, 4);
    rchk("orl_acc", ACC, 32'hbf);
    rchk("orl_status", STS, 32'h1b);
    apb(ACC, 1'b1, 32'h0);
    run(32'h0900, 1'b0, 4);
    rchk("orl_zero", STS, 32'h0f);
    apb(MEM_F, 1'b1, 32'h13);
    apb(ACC, 1'b1, 32'h91);
    run(32'h1120, 1'b0, 4);
    rchk("orf_acc", ACC, 32'h93);
    rchk("orf_file", MEM_F, 32'h13);
    rchk("orf_status", STS, 32'h1b);
    // Access bank, f below the indexed limit but extended set off, result to file
    apb(isl_pkg::ISL_OFF_BANK, 1'b1, 32'h0);
    apb(8'hb0, 1'b1, 32'h0c);
    apb(ACC, 1'b1, 32'h90);
    run(32'h1230, 1'b0, 4);
    rchk("orf_dest_file", 8'hb0, 32'h9c);
    rchk("orf_dest_acc", ACC, 32'h90);
    rchk("orf_dest_status", STS, 32'h1b);
    apb(isl_pkg::ISL_OFF_BANK, 1'b1, 32'h2);
  endtask

  // Pointer 2 then aims indexed mode into bank 2 at file 0x15
  task automatic test_ptr();
    apb(STS, 1'b1, 32'h1f);
    run(32'hf010_ee22, 1'b0, 8);
    rchk("ptr_value", isl_pkg::ISL_OFF_FPTR2, 32'h210);
    rchk("ptr_status", STS, 32'h1f);
    run(32'hf0cd_ee0a, 1'b0, 8);
    rchk("ptr0_value", isl_pkg::ISL_OFF_FPTR0, 32'hacd);
    run(32'hf0ff_ee3f, 1'b0, 8);
    rchk("ptr_idx3", isl_pkg::ISL_OFF_FPTR1, 32'h0);
    apb(8'h95, 1'b1, 32'h41);
    run(32'h4a05, 1'b1, 8);
    rchk("idx_file", 8'h95, 32'h42);
    apb(8'h24, 1'b0, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
  endtask

  // Reset in mid-instruction clears state; the block works again right after
  task automatic test_reset();
    apb(ACC, 1'b1, 32'h77);
    apb(isl_pkg::ISL_OFF_INSTR, 1'b1, 32'hf0cd_ee1a);
    apb(isl_pkg::ISL_OFF_CTRL, 1'b1, 32'h1);
    repeat (3) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("busy_mid_reset", 32'h0, {31'h0, busy});
    presetn <= 1'b1;
    @(posedge pclk);
    rchk("rst_acc", ACC, 32'h0);
    rchk("rst_ptr1", isl_pkg::ISL_OFF_FPTR1, 32'h0);
    run(32'h0935, 1'b0, 4);
    rchk("rst_or", ACC, 32'h35);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge pclk);
    chk("busy_in_reset", 32'h0, {31'h0, busy});
    presetn <= 1'b1;
    @(posedge pclk);
    test_incr();
    test_or();
    test_ptr();
    test_reset();
    print_verdict();
  end
endmodule
